// file: design/fault_channel.sv
module fault_channel
  import spi_diag_pkg::*;
#(
  parameter int FILTER = FILTER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic on_req,
  input wire logic scb_det,
  input wire logic ol_det,
  input wire logic scg_det,
  input wire logic ot_det,
  input wire logic scl_en,
  input wire logic clear_diag,
  output logic gate,
  output logic [1:0] code
);
  localparam int CW = $clog2(FILTER + 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(FILTER - 1);
  localparam logic [CW-1:0] FILT_FULL = CW'(FILTER);

  logic on_req_q;
  logic shut_q;
  logic gate_q;
  logic [1:0] code_q;
  logic [CW-1:0] ol_cnt_q;
  logic [CW-1:0] scg_cnt_q;
  logic toggle;
  logic hot;
  logic trip;
  logic ol_fire;
  logic scg_fire;

  assign toggle = on_req & ~on_req_q;
  assign hot = (scb_det | ot_det) & gate_q;
  assign trip = hot & ~scl_en;
  assign ol_fire = ol_det & ~gate_q & (ol_cnt_q == FILT_LAST);
  assign scg_fire = scg_det & ~gate_q & (scg_cnt_q == FILT_LAST);
  assign gate = gate_q;
  assign code = code_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_req_q <= 1'b0;
    end else begin
      on_req_q <= on_req;
    end
  end

  // Shutdown latch, released by a fresh switch-on request.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shut_q <= 1'b0;
    end else if (trip) begin
      shut_q <= 1'b1;
    end else if (toggle) begin
      shut_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= on_req & ~shut_q & ~trip;
    end
  end

  // Off-state comparator filters, identical for both conditions.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ol_cnt_q <= '0;
      scg_cnt_q <= '0;
    end else begin
      if (gate_q || !ol_det) begin
        ol_cnt_q <= '0;
      end else if (ol_cnt_q != FILT_FULL) begin
        ol_cnt_q <= ol_cnt_q + 1'b1;
      end
      if (gate_q || !scg_det) begin
        scg_cnt_q <= '0;
      end else if (scg_cnt_q != FILT_FULL) begin
        scg_cnt_q <= scg_cnt_q + 1'b1;
      end
    end
  end

  // Fault code; a new fault wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      code_q <= FAULT_NONE;
    end else if (hot) begin
      code_q <= FAULT_SCB;
    end else if (code_q == FAULT_SCB && !clear_diag) begin
      code_q <= FAULT_SCB;
    end else if (scg_fire) begin
      code_q <= FAULT_SCG;
    end else if (ol_fire) begin
      code_q <= FAULT_OL;
    end else if (clear_diag) begin
      code_q <= FAULT_NONE;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_scb_shutoff: assert property (trip |=> !gate_q && code_q == FAULT_SCB)
    else $error("short to battery did not switch the channel off");
  a_scb_latched: assert property (code_q == FAULT_SCB && !clear_diag |=> code_q == FAULT_SCB)
    else $error("short to battery code was lost without a clear");
  a_scb_when_on: assert property (code_q != FAULT_SCB ##1 code_q == FAULT_SCB |-> $past(gate_q))
    else $error("short to battery flagged while channel off");
  a_toggle_restart: assert property (shut_q && toggle ##1 on_req && !trip |=> gate_q)
    else $error("toggling the request did not restart the channel");
  a_ol_filtered: assert property (code_q != FAULT_OL ##1 code_q == FAULT_OL |-> $past(ol_cnt_q) == FILT_LAST)
    else $error("open load set before the filter time");
  a_scg_filtered: assert property ($rose(scg_cnt_q == FILT_LAST) |-> $past(scg_det && !gate_q))
    else $error("short to ground filter advanced without the condition");
endmodule // fault_channel

// file: design/lowside_switch_spi_diag.sv
module lowside_switch_spi_diag
  import spi_diag_pkg::*;
#(
  parameter int FILTER = FILTER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic [NUM_PAR-1:0] channel_control_input,
  input wire logic [NUM_CH-1:0] serial_on,
  input wire logic [NUM_CH-1:0] scb_cmp,
  input wire logic [NUM_CH-1:0] ol_cmp,
  input wire logic [NUM_CH-1:0] scg_cmp,
  input wire logic [NUM_CH-1:0] ot_cmp,
  output logic [NUM_CH-1:0] channel_gate,
  output logic [2*NUM_CH-1:0] diagnostic_regs,
  output logic parallel_input_select,
  output logic [NUM_CH-1:0] current_limit_en
);
  localparam int PIN_W = 3 + NUM_PAR + 4 * NUM_CH;

  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic [NUM_PAR-1:0] inp_s;
  logic [NUM_CH-1:0] scb_s;
  logic [NUM_CH-1:0] ol_s;
  logic [NUM_CH-1:0] scg_s;
  logic [NUM_CH-1:0] ot_s;

  logic sck_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  frame_state_t state_q;
  logic [4:0] fall_cnt_q;
  logic [4:0] rise_cnt_q;
  logic [15:0] rx_q;
  logic [7:0] resp_q;
  logic [7:0] resp_d;
  logic so_q;
  logic [7:0] cfg_q;
  logic clear_q;
  logic [7:0] cmd_now;
  logic [7:0] group3_byte;
  logic [15:0] tx_word;
  logic [3:0] tx_idx;
  logic addr_bad;
  logic commit;

  // Two-stage synchroniser for every pin from outside the clock domain except serial_on.
  // It resets to the idle pin levels, so no false clock edge or fault follows reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= SYNC_IDLE;
      pin_sync_q <= SYNC_IDLE;
    end else begin
      pin_meta_q <= {spi_cs_n, spi_sck, spi_si, channel_control_input, scb_cmp, ol_cmp, scg_cmp, ot_cmp};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {cs_n_s, sck_s, si_s, inp_s, scb_s, ol_s, scg_s, ot_s} = pin_sync_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  assign cs_act = ~cs_n_s;
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign cmd_now = {rx_q[6:0], si_s};
  assign addr_bad = sck_fall && fall_cnt_q == ADDR_LAST_FALL && {rx_q[0], si_s} != DEVICE_ADDR;
  assign commit = state_q == FR_ACTIVE && !cs_act && fall_cnt_q == FRAME_LEN;

  // Frame tracking: selection opens a frame, a foreign address parks it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= FR_IDLE;
    end else if (!cs_act) begin
      state_q <= FR_IDLE;
    end else begin
      unique case (state_q)
        FR_IDLE: begin
          state_q <= FR_ACTIVE;
        end
        FR_ACTIVE: begin
          if (addr_bad) begin
            state_q <= FR_REJECT;
          end
        end
        FR_REJECT: begin
          state_q <= FR_REJECT;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fall_cnt_q <= '0;
      rise_cnt_q <= '0;
    end else if (state_q == FR_IDLE) begin
      fall_cnt_q <= '0;
      rise_cnt_q <= '0;
    end else begin
      if (sck_fall && fall_cnt_q != FRAME_LEN) begin
        fall_cnt_q <= fall_cnt_q + 1'b1;
      end
      if (sck_rise && rise_cnt_q != FRAME_LEN) begin
        rise_cnt_q <= rise_cnt_q + 1'b1;
      end
    end
  end

  // Input shifts in MSB first on falling edges.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_q <= '0;
    end else if (state_q == FR_ACTIVE && sck_fall && fall_cnt_q != FRAME_LEN) begin
      rx_q <= {rx_q[14:0], si_s};
    end
  end

  // Group three: channel eight in the top bit pair.
  always_comb begin
    group3_byte = '0;
    for (int k = 0; k < 4; k++) begin
      group3_byte[7-2*k -: 2] = diagnostic_regs[2*(GROUP3_FIRST_CH+k) +: 2];
    end
  end

  always_comb begin
    resp_d = '0;
    if (cmd_now == READ_DIAG_GROUP3_CMD) begin
      resp_d = group3_byte;
    end
  end

  // Reply byte is chosen as soon as the command byte is complete.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resp_q <= '0;
    end else if (state_q == FR_ACTIVE && sck_fall && fall_cnt_q == CMD_LAST_FALL) begin
      resp_q <= resp_d;
    end
  end

  assign tx_word = {CHECK_BYTE, resp_q};
  assign tx_idx = 4'hf - rise_cnt_q[3:0];

  // Output bits move MSB first on rising edges; input is never echoed.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      so_q <= 1'b0;
    end else if (state_q == FR_ACTIVE && sck_rise && rise_cnt_q != FRAME_LEN) begin
      so_q <= tx_word[tx_idx];
    end
  end

  assign spi_so = so_q;
  // The drive stops as soon as the select is seen released; the frame closes a cycle later.
  assign spi_so_oe = state_q == FR_ACTIVE && cs_act;

  // Commands take effect only when a whole frame closes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CONFIG_RESET;
    end else if (commit && rx_q[15:8] == WRITE_CONFIG_CMD) begin
      cfg_q <= rx_q[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= commit && rx_q[15:8] == CLEAR_DIAGNOSTICS_CMD;
    end
  end

  assign parallel_input_select = cfg_q[CFG_PIS_BIT];

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic on_req;
    logic scl_en;
    if (i < NUM_PAR) begin : g_par
      assign on_req = cfg_q[CFG_PIS_BIT] ? ~inp_s[i] : serial_on[i];
    end else begin : g_ser
      assign on_req = serial_on[i];
    end
    assign scl_en = SCL_CAPABLE[i] & ~cfg_q[scl_cfg_bit(i)];
    assign current_limit_en[i] = scl_en;
    fault_channel #(
      .FILTER(FILTER)
    ) u_ch (
      .sys_clk(sys_clk),
      .rst(rst),
      .on_req(on_req),
      .scb_det(scb_s[i]),
      .ol_det(ol_s[i]),
      .scg_det(scg_s[i]),
      .ot_det(ot_s[i]),
      .scl_en(scl_en),
      .clear_diag(clear_q),
      .gate(channel_gate[i]),
      .code(diagnostic_regs[2*i +: 2])
    );
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_oe_when_sel: assert property (spi_so_oe |-> cs_act)
    else $error("output driven without chip select");
  a_addr_reject: assert property (state_q == FR_ACTIVE && cs_act && addr_bad |=> !spi_so_oe)
    else $error("output stayed on for a foreign address");
  a_so_on_rise: assert property (!sck_rise |=> $stable(so_q))
    else $error("serial output moved without a rising edge");
  a_si_on_fall: assert property (!sck_fall |=> $stable(rx_q))
    else $error("serial input shifted without a falling edge");
  a_read_same: assert property (state_q == FR_ACTIVE && sck_fall && fall_cnt_q == CMD_LAST_FALL
                                && cmd_now == READ_DIAG_GROUP3_CMD |=> resp_q == $past(group3_byte))
    else $error("read reply not ready within the frame");
  a_write_zero: assert property (state_q == FR_ACTIVE && sck_fall && fall_cnt_q == CMD_LAST_FALL
                                 && cmd_now == WRITE_CONFIG_CMD |=> resp_q == 8'h00)
    else $error("write frame reply byte not zero");
  a_check_first: assert property (state_q == FR_ACTIVE && sck_rise && rise_cnt_q < BYTE_LEN
                                  |=> so_q == CHECK_BYTE[3'h7 - $past(rise_cnt_q[2:0])])
    else $error("first output byte is not the check byte");
  a_reply_bits: assert property (state_q == FR_ACTIVE && sck_rise && rise_cnt_q >= BYTE_LEN
                                 && rise_cnt_q != FRAME_LEN |=> so_q == $past(resp_q[3'h7 - rise_cnt_q[2:0]]))
    else $error("reply byte not shifted MSB first");
  a_cfg_write: assert property (commit && rx_q[15:8] == WRITE_CONFIG_CMD
                                |=> parallel_input_select == $past(rx_q[CFG_PIS_BIT]))
    else $error("configuration write not applied");
  a_short_frame: assert property (state_q == FR_ACTIVE && !cs_act && fall_cnt_q != FRAME_LEN
                                  |=> $stable(cfg_q) ##1 !clear_q)
    else $error("incomplete frame took effect");
  a_oe_release: assert property (!cs_act |=> !spi_so_oe)
    else $error("output still driven after deselect");

  c_read_group3: cover property (commit && rx_q[15:8] == READ_DIAG_GROUP3_CMD);
  c_write_config: cover property (commit && rx_q[15:8] == WRITE_CONFIG_CMD);
  c_clear_diag: cover property (clear_q);
  c_reject: cover property (state_q == FR_REJECT);
  c_cut_frame: cover property (state_q == FR_ACTIVE && !cs_act && fall_cnt_q != FRAME_LEN);
endmodule // lowside_switch_spi_diag

// file: design/spi_diag_pkg.sv
package spi_diag_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FILTER_TIME_NS = 10000;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_CH = 18;
  localparam int NUM_PAR = 16;
  // Synchroniser value after reset: deselected, clock low, inputs off, comparators quiet.
  localparam logic [3+NUM_PAR+4*NUM_CH-1:0] SYNC_IDLE = {3'h4, {NUM_PAR{1'b1}}, {4*NUM_CH{1'b0}}};
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] CMD_LAST_FALL = 5'h07;
  localparam logic [4:0] ADDR_LAST_FALL = 5'h01;
  localparam logic [4:0] BYTE_LEN = 5'h08;
  localparam logic [1:0] DEVICE_ADDR = 2'h0;
  localparam logic [7:0] WRITE_CONFIG_CMD = 8'h2e;
  localparam logic [7:0] READ_DIAG_GROUP3_CMD = 8'h14;
  localparam logic [7:0] CLEAR_DIAGNOSTICS_CMD = 8'h3c;
  // Check byte value is arbitrary.
  localparam logic [7:0] CHECK_BYTE = 8'h5a;
  localparam logic [7:0] CONFIG_RESET = 8'hf0;
  localparam int CFG_PIS_BIT = 1;
  localparam int GROUP3_FIRST_CH = 8;
  localparam logic [NUM_CH-1:0] SCL_CAPABLE = 18'h3c300;
  typedef enum logic [1:0] {
    FAULT_SCG = 2'h0,
    FAULT_OL = 2'h1,
    FAULT_SCB = 2'h2,
    FAULT_NONE = 2'h3
  } fault_code_t;
  typedef enum {FR_IDLE, FR_ACTIVE, FR_REJECT} frame_state_t;
  // Configuration bit that disables current limiting for a channel index.
  function automatic int scl_cfg_bit(input int ch);
    if (ch == 8) begin
      return 4;
    end else if (ch == 9) begin
      return 5;
    end else if (ch < 16) begin
      return 6;
    end
    return 7;
  endfunction
endpackage

// file: tb/spi_master_model.sv
module spi_master_model (
  input wire logic sys_clk,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_si,
  output logic frame_done,
  output logic [15:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
    frame_done = 1'b0;
    rx_word = 16'h0000;
  end

  // Half of the 48 ns serial clock period.
  task automatic half_period();
    repeat (6) @(negedge sys_clk);
  endtask

  // One selected frame of nbits clocks, sixteen by default; the reply is sampled at each falling edge.
  task automatic xfer(input logic [15:0] tx, input logic note, input int nbits = 16);
    int i;
    @(negedge sys_clk);
    spi_cs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (i = 15; i >= 16 - nbits; i--) begin
      spi_si = tx[i];
      spi_sck = 1'b1;
      half_period();
      // A line that is not driven shows the inverse of its last level.
      rx_word[i] = spi_so_oe ? spi_so : ~spi_so;
      spi_sck = 1'b0;
      half_period();
    end
    spi_cs_n = 1'b1;
    // A released input line shows the inverse of its last bit.
    spi_si = ~spi_si;
    if (note) begin
      frame_done = 1'b1;
      @(negedge sys_clk);
      frame_done = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
  endtask
endmodule // spi_master_model

// file: tb/testbench.sv
module testbench
  import spi_diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FILT = 8;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic spi_cs_n;
  logic spi_sck;
  logic spi_si;
  logic spi_so;
  logic spi_so_oe;
  logic frame_done;
  logic [15:0] rx_word;
  logic [NUM_PAR-1:0] channel_control_input = '1;
  logic [NUM_CH-1:0] serial_on = '0;
  logic [NUM_CH-1:0] scb_cmp = '0;
  logic [NUM_CH-1:0] ol_cmp = '0;
  logic [NUM_CH-1:0] scg_cmp = '0;
  logic [NUM_CH-1:0] ot_cmp = '0;
  logic [NUM_CH-1:0] channel_gate;
  logic [2*NUM_CH-1:0] diagnostic_regs;
  logic parallel_input_select;
  logic [NUM_CH-1:0] current_limit_en;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int n_tests = 0;

  always #2 sys_clk = ~sys_clk;

  lowside_switch_spi_diag #(.FILTER(FILT)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .channel_control_input(channel_control_input),
    .serial_on(serial_on), .scb_cmp(scb_cmp), .ol_cmp(ol_cmp), .scg_cmp(scg_cmp), .ot_cmp(ot_cmp),
    .channel_gate(channel_gate), .diagnostic_regs(diagnostic_regs),
    .parallel_input_select(parallel_input_select), .current_limit_en(current_limit_en)
  );

  spi_master_model i_master (
    .sys_clk(sys_clk), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_si(spi_si), .frame_done(frame_done), .rx_word(rx_word)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic frame(input logic [15:0] tx, input logic [15:0] exp);
    exp_q.push_back(exp);
    i_master.xfer(tx, 1'b1);
  endtask

  // Each frame that raises frame_done is compared with the oldest noted reply.
  always @(posedge frame_done) begin
    if (exp_q.size() == 0) begin
      chk(64'h1, 64'h0, "reply without note");
    end else begin
      chk(rx_word, exp_q.pop_front(), "frame reply");
    end
  end

  initial begin
    void'($urandom(32'h6c3b));
    cyc(1);
    chk(diagnostic_regs, {NUM_CH{2'b11}}, "reset codes");
    chk({parallel_input_select, current_limit_en, channel_gate}, 0, "reset outputs");
    cyc(1);
    rst = 1'b0;
    cyc(4);
    $display("test reset done");
    scg_cmp[8] = 1'b1;
    ol_cmp[9] = 1'b1;
    scb_cmp[12] = 1'b1;
    serial_on[11] = 1'b1;
    serial_on[13] = 1'b1;
    cyc(4);
    chk(channel_gate[11], 1'b1, "serial on");
    scb_cmp[11] = 1'b1;
    ot_cmp[13] = 1'b1;
    cyc(FILT + 8);
    chk(channel_gate[11], 1'b0, "battery short shutdown");
    chk(diagnostic_regs[25:24], 2'b11, "battery short while off");
    chk({channel_gate[13], diagnostic_regs[27:26]}, 3'b010, "over temperature");
    frame({READ_DIAG_GROUP3_CMD, 8'h00}, {CHECK_BYTE, 8'h1e});
    $display("test fault capture done");
    scb_cmp = '0;
    ot_cmp = '0;
    scg_cmp = '0;
    ol_cmp = '0;
    cyc(6);
    chk(diagnostic_regs[23:22], 2'b10, "battery code latched");
    serial_on[11] = 1'b0;
    cyc(3);
    serial_on[11] = 1'b1;
    cyc(4);
    chk(channel_gate[11], 1'b1, "restart after toggle");
    frame({CLEAR_DIAGNOSTICS_CMD, 8'h00}, {CHECK_BYTE, 8'h00});
    cyc(8);
    chk(diagnostic_regs, {NUM_CH{2'b11}}, "codes cleared");
    $display("test latch and clear done");
    frame({WRITE_CONFIG_CMD, 8'h02}, {CHECK_BYTE, 8'h00});
    cyc(8);
    chk(parallel_input_select, 1'b1, "parallel select set");
    chk(current_limit_en, SCL_CAPABLE, "static limits on");
    frame({2'b10, 6'h2e, 8'($urandom)}, {CHECK_BYTE[7:6], {14{~CHECK_BYTE[6]}}});
    cyc(8);
    chk({parallel_input_select, current_limit_en}, {1'b1, SCL_CAPABLE}, "foreign address ignored");
    i_master.xfer({WRITE_CONFIG_CMD, 8'h00}, 1'b0, 8);
    i_master.xfer(16'h0000, 1'b0, 8);
    cyc(8);
    chk({parallel_input_select, current_limit_en}, {1'b1, SCL_CAPABLE}, "cut frames ignored");
    $display("test configuration done");
    channel_control_input[8] = 1'b0;
    channel_control_input[0] = 1'b0;
    cyc(6);
    chk({channel_gate[8], channel_gate[0]}, 2'b11, "parallel on");
    scb_cmp[8] = 1'b1;
    scb_cmp[0] = 1'b1;
    cyc(8);
    chk({channel_gate[8], channel_gate[0]}, 2'b10, "limit keeps gate");
    chk({diagnostic_regs[17:16], diagnostic_regs[1:0]}, 4'b1010, "limit codes");
    $display("test current limit done");
    tally_and_finish();
  end

  initial begin
    #100us;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule // testbench
